// ===== rtl/scdsy_pkg.sv
// Overview of operation
// - Divide sample clock by ratio one to eight
// - Duty cycle corrector enabled after reset
// - Control bits choose every-pulse or first-pulse realign
// - Accepted alignment pulse resets divider counter
// - Sample captured on conversion clock rising edge
// - Stage codes corrected into one 14-bit word
// - Data outputs high impedance during power-down
package scdsy_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [12:0] ADDR_POWER = 13'h0008;
    localparam logic [12:0] ADDR_DCC = 13'h0009;
    localparam logic [12:0] ADDR_RATIO = 13'h000B;
    localparam logic [12:0] ADDR_SYNC_CTRL = 13'h003A;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int POS_PD = 0;
    localparam int POS_DCC_EN = 0;
    localparam int POS_SYNC_EN = 1;
    localparam int POS_SYNC_FIRST = 2;
    localparam int POS_SYNC_ARMED = 3;
    localparam logic RST_PD = 1'b0;
    localparam logic RST_DCC_EN = 1'b1;
    localparam logic [2:0] RST_RATIO_M1 = 3'h0;
    localparam logic [7:0] RST_SYNC_CTRL = 8'h00;

    // ************************************************************
    // Serial port, pin timing and pipeline sizes
    // ************************************************************
    localparam int SYNC_STAGES = 3;
    localparam logic [4:0] INSTR_BITS = 5'h10;
    localparam logic [4:0] DATA_BITS = 5'h08;
    localparam int N_STAGES = 6;
    localparam logic [15:0] WORD_MAX = 16'h3FFF;

    // Serial port states
    typedef enum logic [3:0] {
        SP_IDLE = 4'b0001,
        SP_INSTR = 4'b0010,
        SP_DATA = 4'b0100,
        SP_DONE = 4'b1000
    } scdsy_sp_state_t;

    // Raw pipeline codes of one channel: 3-bit stage codes, last flash
    typedef struct packed {
        logic [N_STAGES-1:0][2:0] res;
        logic [1:0] flash;
    } scdsy_codes_t;

    // Corrected output of one channel
    typedef struct packed {
        logic [13:0] word;
        logic ovr;
    } scdsy_word_t;

endpackage

// ===== rtl/scdsy_divider.sv
`timescale 1ns/10ps
`default_nettype none
module scdsy_divider (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Control
    input wire logic [2:0] ratio_m1_i,
    input wire logic realign_i,
    // Divided clock
    output logic conv_clk_o,
    output logic conv_stb_o
);

    // ************************************************************
    // Divider counter
    // ************************************************************
    logic [2:0] cnt_r; // Position inside one divided period
    logic [2:0] cnt_nxt;
    logic [3:0] ratio; // Divide ratio one to eight

    assign ratio = {1'b0, ratio_m1_i} + 4'h1;

    // Next count: wraps at the ratio, realign returns to start
    always_comb begin
        if (realign_i) begin
            cnt_nxt = 3'h0;
        end else if (cnt_r >= ratio_m1_i) begin
            cnt_nxt = 3'h0;
        end else begin
            cnt_nxt = cnt_r + 3'h1;
        end
    end

    // Counter register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Divided clock high over first half, strobe at its rising edge
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_clk_o <= 1'b0;
            conv_stb_o <= 1'b0;
        end else begin
            conv_clk_o <= ({cnt_nxt, 1'b0} < ratio);
            conv_stb_o <= (cnt_nxt == 3'h0);
        end
    end

endmodule
`default_nettype wire

// ===== rtl/scdsy_top.sv
`timescale 1ns/10ps
`default_nettype none
module scdsy_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Serial port pins
    input wire logic sclk_i,
    input wire logic csb_n_i,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_o,
    // Alignment and power-down pins
    input wire logic sync_i,
    input wire logic pdwn_i,
    // Pipeline stage codes per channel
    input wire scdsy_pkg::scdsy_codes_t codes_i [2],
    // Corrected data per channel
    output scdsy_pkg::scdsy_word_t data_o [2],
    output logic data_valid_o,
    output logic data_oe_o,
    // Clocking outputs
    output logic conv_clk_o,
    output logic dcc_enable_o
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int N_PINS = 5;
    logic [N_PINS-1:0] pin_raw; // Pins before synchronising
    logic [N_PINS-1:0] pin_f1_r; // First stage
    logic [N_PINS-1:0] pin_f2_r; // Second stage
    logic [N_PINS-1:0] pin_f3_r; // Third stage
    logic [N_PINS-1:0] pin_q_r; // Accepted level
    logic [N_PINS-1:0] pin_prev_r; // Accepted level one cycle back

    assign pin_raw = {pdwn_i, sync_i, sdio_i, csb_n_i, sclk_i};

    // Three flops per pin, level accepted when stages two and three agree
    genvar gp;
    generate
        for (gp = 0; gp < N_PINS; gp = gp + 1) begin : g_pin
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    // Chip select stages rest high so no false select follows reset
                    pin_f1_r[gp] <= (gp == 1) ? 1'b1 : 1'b0;
                    pin_f2_r[gp] <= (gp == 1) ? 1'b1 : 1'b0;
                    pin_f3_r[gp] <= (gp == 1) ? 1'b1 : 1'b0;
                    pin_q_r[gp] <= (gp == 1) ? 1'b1 : 1'b0;
                    pin_prev_r[gp] <= (gp == 1) ? 1'b1 : 1'b0;
                end else begin
                    pin_f1_r[gp] <= pin_raw[gp];
                    pin_f2_r[gp] <= pin_f1_r[gp];
                    pin_f3_r[gp] <= pin_f2_r[gp];
                    if (pin_f2_r[gp] == pin_f3_r[gp]) begin
                        pin_q_r[gp] <= pin_f3_r[gp];
                    end
                    pin_prev_r[gp] <= pin_q_r[gp];
                end
            end
        end
    endgenerate

    logic sclk_rise; // Serial clock rising edge
    logic sclk_fall; // Serial clock falling edge
    logic csb_n; // Chip select, low active
    logic sdio_in; // Serial data in
    logic sync_rise; // Alignment pulse edge
    logic pdwn_pin; // Power-down pin level

    assign sclk_rise = pin_q_r[0] & ~pin_prev_r[0];
    assign sclk_fall = ~pin_q_r[0] & pin_prev_r[0];
    assign csb_n = pin_q_r[1];
    assign sdio_in = pin_q_r[2];
    assign sync_rise = pin_q_r[3] & ~pin_prev_r[3];
    assign pdwn_pin = pin_q_r[4];

    // ************************************************************
    // Serial port
    // ************************************************************
    scdsy_pkg::scdsy_sp_state_t sp_state_r; // Port state
    logic [4:0] bit_cnt_r; // Bits taken in current phase
    logic [15:0] instr_r; // Instruction shift register
    logic [7:0] shift_r; // Data shift register
    logic wr_stb_r; // One-cycle register write strobe
    logic [12:0] wr_addr_r; // Write address
    logic [7:0] wr_data_r; // Write data
    logic [7:0] rd_byte; // Read mux

    // Address match, used by write decode and read mux
    function automatic logic addr_is(input logic [12:0] a, input logic [12:0] off);
        addr_is = (a == off);
    endfunction

    // Port sequencer: 16-bit instruction, then one data byte
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sp_state_r <= scdsy_pkg::SP_IDLE;
            bit_cnt_r <= 5'h00;
            instr_r <= 16'h0000;
            shift_r <= 8'h00;
            wr_stb_r <= 1'b0;
            wr_addr_r <= 13'h0000;
            wr_data_r <= 8'h00;
            sdio_o <= 1'b0;
            sdio_oe_o <= 1'b0;
        end else begin
            wr_stb_r <= 1'b0;
            if (csb_n) begin
                // Deselected: abort and release data pin
                sp_state_r <= scdsy_pkg::SP_IDLE;
                sdio_oe_o <= 1'b0;
            end else begin
                case (sp_state_r)
                    scdsy_pkg::SP_IDLE: begin
                        sp_state_r <= scdsy_pkg::SP_INSTR;
                        bit_cnt_r <= 5'h00;
                    end
                    scdsy_pkg::SP_INSTR: begin
                        if (sclk_rise) begin
                            instr_r <= {instr_r[14:0], sdio_in};
                            bit_cnt_r <= bit_cnt_r + 5'h01;
                            if (bit_cnt_r == scdsy_pkg::INSTR_BITS - 5'h01) begin
                                sp_state_r <= scdsy_pkg::SP_DATA;
                                bit_cnt_r <= 5'h00;
                                // Read: present first bit at once
                                if (instr_r[14]) begin
                                    shift_r <= rd_byte;
                                    sdio_o <= rd_byte[7];
                                    sdio_oe_o <= 1'b1;
                                end
                            end
                        end
                    end
                    scdsy_pkg::SP_DATA: begin
                        if (instr_r[15]) begin
                            // Read: shift out on falling edges
                            if (sclk_rise) begin
                                bit_cnt_r <= bit_cnt_r + 5'h01;
                                if (bit_cnt_r == scdsy_pkg::DATA_BITS - 5'h01) begin
                                    sp_state_r <= scdsy_pkg::SP_DONE;
                                end
                            end
                            if (sclk_fall) begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sdio_o <= shift_r[6];
                            end
                        end else if (sclk_rise) begin
                            // Write: shift in, commit on eighth bit
                            shift_r <= {shift_r[6:0], sdio_in};
                            bit_cnt_r <= bit_cnt_r + 5'h01;
                            if (bit_cnt_r == scdsy_pkg::DATA_BITS - 5'h01) begin
                                sp_state_r <= scdsy_pkg::SP_DONE;
                                wr_stb_r <= 1'b1;
                                wr_addr_r <= instr_r[12:0];
                                wr_data_r <= {shift_r[6:0], sdio_in};
                            end
                        end
                    end
                    scdsy_pkg::SP_DONE: begin
                        // Wait for deselect, release pin after last bit
                        if (sclk_fall) begin
                            sdio_oe_o <= 1'b0;
                        end
                    end
                    default: begin
                        sp_state_r <= scdsy_pkg::SP_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic pd_r; // Software power-down
    logic dcc_en_r; // Duty cycle corrector enable
    logic [2:0] ratio_m1_r; // Divide ratio minus one
    logic [7:0] sync_ctrl_r; // Alignment control
    logic armed_r; // First-pulse realign armed
    logic realign; // Accepted alignment pulse
    logic wr_sync; // Write to alignment control

    // Read value of a register; unmapped reads as zero
    function automatic logic [7:0] rd_byte_of(input logic [12:0] a);
        rd_byte_of = 8'h00;
        if (addr_is(a, scdsy_pkg::ADDR_POWER)) begin
            rd_byte_of[scdsy_pkg::POS_PD] = pd_r;
        end else if (addr_is(a, scdsy_pkg::ADDR_DCC)) begin
            rd_byte_of[scdsy_pkg::POS_DCC_EN] = dcc_en_r;
        end else if (addr_is(a, scdsy_pkg::ADDR_RATIO)) begin
            rd_byte_of[2:0] = ratio_m1_r;
        end else if (addr_is(a, scdsy_pkg::ADDR_SYNC_CTRL)) begin
            rd_byte_of = sync_ctrl_r;
            rd_byte_of[scdsy_pkg::POS_SYNC_ARMED] = armed_r;
        end
    endfunction

    // Read value for the address completed by the current instruction bit
    assign rd_byte = rd_byte_of({instr_r[11:0], sdio_in});
    assign wr_sync = wr_stb_r & addr_is(wr_addr_r, scdsy_pkg::ADDR_SYNC_CTRL);

    // Writable registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pd_r <= scdsy_pkg::RST_PD;
            dcc_en_r <= scdsy_pkg::RST_DCC_EN;
            ratio_m1_r <= scdsy_pkg::RST_RATIO_M1;
            sync_ctrl_r <= scdsy_pkg::RST_SYNC_CTRL;
        end else if (wr_stb_r) begin
            if (addr_is(wr_addr_r, scdsy_pkg::ADDR_POWER)) begin
                pd_r <= wr_data_r[scdsy_pkg::POS_PD];
            end
            if (addr_is(wr_addr_r, scdsy_pkg::ADDR_DCC)) begin
                dcc_en_r <= wr_data_r[scdsy_pkg::POS_DCC_EN];
            end
            if (addr_is(wr_addr_r, scdsy_pkg::ADDR_RATIO)) begin
                ratio_m1_r <= wr_data_r[2:0];
            end
            if (wr_sync) begin
                // Only the two mode bits are stored
                sync_ctrl_r <= wr_data_r & 8'h06;
            end
        end
    end

    assign realign = sync_rise & sync_ctrl_r[scdsy_pkg::POS_SYNC_EN]
                   & (~sync_ctrl_r[scdsy_pkg::POS_SYNC_FIRST] | armed_r);

    // Arm on write, disarm on first accepted pulse; the write wins
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            armed_r <= 1'b0;
        end else if (wr_sync) begin
            armed_r <= 1'b1;
        end else if (realign) begin
            armed_r <= 1'b0;
        end
    end

    assign dcc_enable_o = dcc_en_r;

    // ************************************************************
    // Divider and sample path
    // ************************************************************
    logic conv_stb; // Rising edge of conversion clock

    scdsy_divider u_div (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .ratio_m1_i(ratio_m1_r),
        .realign_i(realign),
        .conv_clk_o(conv_clk_o),
        .conv_stb_o(conv_stb)
    );

    // Overlapped sum of stage codes, saturated to 14 bits
    function automatic scdsy_pkg::scdsy_word_t correct(input scdsy_pkg::scdsy_codes_t c);
        logic [15:0] acc;
        acc = {14'h0000, c.flash};
        for (int k = 0; k < scdsy_pkg::N_STAGES; k++) begin
            acc = acc + 16'({13'h0000, c.res[k]} << (2 * k + 2));
        end
        correct.ovr = (acc > scdsy_pkg::WORD_MAX);
        correct.word = correct.ovr ? 14'h3FFF : acc[13:0];
    endfunction

    scdsy_pkg::scdsy_codes_t cap_r [2]; // Captured codes
    logic cap_vld_r; // Capture happened last cycle

    genvar gc;
    generate
        for (gc = 0; gc < 2; gc = gc + 1) begin : g_chan
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cap_r[gc] <= '0;
                end else if (conv_stb) begin
                    cap_r[gc] <= codes_i[gc];
                end
            end
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    data_o[gc] <= '0;
                end else if (cap_vld_r) begin
                    data_o[gc] <= correct(cap_r[gc]);
                end
            end
        end
    endgenerate

    // Valid pulse follows each capture by one cycle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cap_vld_r <= 1'b0;
            data_valid_o <= 1'b0;
        end else begin
            cap_vld_r <= conv_stb;
            data_valid_o <= cap_vld_r;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= ~(pd_r | pdwn_pin);
        end
    end

endmodule
`default_nettype wire

// ===== sim/scdsy_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module scdsy_top_asserts (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Pins from the board
    input wire logic csb_n_i,
    input wire logic pdwn_i,
    // Outputs of the block
    input wire logic sdio_oe_o,
    input wire scdsy_pkg::scdsy_word_t data_o [2],
    input wire logic data_valid_o,
    input wire logic data_oe_o,
    input wire logic conv_clk_o,
    input wire logic dcc_enable_o
);
    // ********
    // Helpers
    // ********
    // Cycles since the last data_valid_o pulse
    logic [4:0] gap_r;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    // Gap counter, saturating so it cannot wrap back into range
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_r <= 5'h00;
        end else if (data_valid_o) begin
            gap_r <= 5'h00;
        end else if (gap_r != 5'h1F) begin
            gap_r <= gap_r + 5'h01;
        end
    end

    // Power-down pin held long enough to pass the synchronisers
    sequence pd_held;
        pdwn_i [*7];
    endsequence

    // Chip select idle long enough to pass the synchronisers
    sequence csb_idle;
        csb_n_i [*7];
    endsequence

    // ********
    // Checks
    // ********
    a_dcc_reset_on: assert property ($rose(reset_n_i) |-> dcc_enable_o)
        else $error("dcc enable low after reset");
    a_pd_outputs_off: assert property (pd_held |-> !data_oe_o)
        else $error("data outputs driven in power-down");
    a_ovr_full_scale: assert property (data_o[0].ovr |-> data_o[0].word == 14'h3FFF)
        else $error("overrange word not at full scale");
    a_word_hold_idle: assert property (!data_valid_o |-> $stable(data_o[0]) && $stable(data_o[1]))
        else $error("data word changed without valid");
    a_low_phase_bound: assert property ($fell(conv_clk_o) |-> ##[1:4] conv_clk_o)
        else $error("conversion clock low too long");
    a_edge_gives_valid: assert property ($rose(conv_clk_o) |-> ##[0:4] data_valid_o)
        else $error("no sample after conversion edge");
    a_valid_gap_bound: assert property (gap_r <= 5'h07)
        else $error("sample gap longer than largest ratio");
    a_sdio_idle_off: assert property (csb_idle |-> !sdio_oe_o)
        else $error("sdio driven while deselected");
endmodule

bind scdsy_top scdsy_top_asserts u_asserts (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .csb_n_i(csb_n_i),
    .pdwn_i(pdwn_i),
    .sdio_oe_o(sdio_oe_o),
    .data_o(data_o),
    .data_valid_o(data_valid_o),
    .data_oe_o(data_oe_o),
    .conv_clk_o(conv_clk_o),
    .dcc_enable_o(dcc_enable_o)
);
`default_nettype wire

// ===== sim/scdsy_sync_src.sv
`timescale 1ns/10ps
`default_nettype none
module scdsy_sync_src (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Request from the bench
    input wire logic fire_i,
    // Alignment pin, shared by every part on the board
    output logic sync_o
);
    // Remaining high cycles of the pulse
    logic [3:0] len_r;

    // common alignment pulse
    // Wide enough to survive the pin synchronisers of every part
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            len_r <= 4'h0;
        end else if (fire_i) begin
            len_r <= 4'h8;
        end else if (len_r != 4'h0) begin
            len_r <= len_r - 4'h1;
        end
    end

    // Pin is driven low between pulses
    assign sync_o = (len_r != 4'h0);
endmodule
`default_nettype wire

// ===== sim/sample_clock_divider_sync_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sample_clock_divider_sync_bench;
    // ********
    // Signals
    // ********
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sclk_i = 1'b0;
    logic csb_n_i = 1'b1;
    logic tb_sdio = 1'b0;
    logic pdwn_i = 1'b0;
    logic fire = 1'b0;
    wire sdio_i;
    wire sync_i;
    logic sdio_o, sdio_oe_o, data_valid_o, data_oe_o, conv_clk_o, dcc_enable_o;
    scdsy_pkg::scdsy_codes_t codes_i [2];
    scdsy_pkg::scdsy_word_t data_o [2];
    scdsy_pkg::scdsy_codes_t tbl [3] = '{20'h00001, 20'h12345, 20'hFFFFF};
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;

    // Shared data wire: the block wins while it drives
    assign sdio_i = sdio_oe_o ? sdio_o : tb_sdio;

    always #5 clk_sys_i = ~clk_sys_i;
    // Free-running cycle count, used as the phase reference
    always @(posedge clk_sys_i) cyc <= cyc + 1;

    scdsy_sync_src u_sync (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .fire_i(fire), .sync_o(sync_i));
    scdsy_top DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i), .csb_n_i(csb_n_i),
        .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .sync_i(sync_i), .pdwn_i(pdwn_i),
        .codes_i(codes_i), .data_o(data_o), .data_valid_o(data_valid_o), .data_oe_o(data_oe_o),
        .conv_clk_o(conv_clk_o), .dcc_enable_o(dcc_enable_o));

    // ********
    // Tasks
    // ********
    // Reference correction: weighted stage sum clipped at full scale
    function automatic scdsy_pkg::scdsy_word_t ref_word(input scdsy_pkg::scdsy_codes_t c);
        logic [17:0] sum;
        scdsy_pkg::scdsy_word_t w;
        sum = {16'h0000, c.flash};
        for (int k = 0; k < scdsy_pkg::N_STAGES; k++) begin
            sum = sum + ({15'h0000, c.res[k]} << (2 * k + 2));
        end
        w.ovr = (sum > 18'h03FFF);
        w.word = w.ovr ? 14'h3FFF : sum[13:0];
        return w;
    endfunction

    // Inputs move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One frame: 16 instruction bits then 8 data bits, MSB first, slow phases
    task automatic spi(input logic rd, input logic [12:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
        logic [23:0] frame;
        frame = {rd, 2'b00, addr, wd};
        rdat = 8'h00;
        csb_n_i = 1'b0;
        tick(8);
        for (int i = 0; i < 24; i++) begin
            tb_sdio = frame[23 - i];
            sclk_i = 1'b0;
            tick(8);
            sclk_i = 1'b1;
            tick(8);
            // Read bits are taken at the end of each high phase
            if (rd && i >= 15 && i < 23) begin
                rdat[22 - i] = sdio_o;
                check("sdio_oe_o", 16'h0001, {15'h0000, sdio_oe_o});
            end
        end
        sclk_i = 1'b0;
        tick(8);
        if (rd) begin
            check("sdio_oe_end", 16'h0000, {15'h0000, sdio_oe_o});
        end
        csb_n_i = 1'b1;
        tick(8);
    endtask

    task automatic reg_wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] unused;
        spi(1'b0, a, d, unused);
    endtask

    task automatic reg_chk(input string name, input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] got;
        spi(1'b1, a, 8'h00, got);
        check(name, {8'h00, exp}, {8'h00, got});
    endtask

    // Bounded wait for a sample; returns the cycle it appeared in
    task automatic wait_valid(output int at);
        int n;
        n = 0;
        while (data_valid_o !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        if (n >= 40) begin
            mismatches++;
            $display("[ERR] data_valid_o expected 1 seen 0");
            test_done();
        end
        at = cyc;
    endtask

    // Alignment pulse launched at a chosen phase of the reference count
    task automatic pulse_at(input int off);
        int n;
        n = 0;
        while (cyc % 8 != off && n < 8) begin
            tick(1);
            n++;
        end
        if (cyc % 8 != off) begin
            mismatches++;
            $display("[ERR] pulse_phase expected %0d seen %0d", off, cyc % 8);
            test_done();
        end
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
        tick(24);
    endtask

    // Hang guard
    initial begin
        #900000;
        mismatches++;
        $display("[ERR] run expected end seen timeout");
        test_done();
    end

    // ********
    // Scenarios
    // ********
    initial begin
        int t0, t1, ph_a, hi;
        scdsy_pkg::scdsy_word_t ew;
        codes_i[0] = '0;
        codes_i[1] = '0;
        tick(3);
        reset_n_i = 1'b1;
        tick(6);
        // Reset values and an unmapped place
        check("dcc_enable_o", 16'h0001, {15'h0000, dcc_enable_o});
        reg_chk("dcc_reg", scdsy_pkg::ADDR_DCC, 8'h01);
        reg_chk("sync_ctrl", scdsy_pkg::ADDR_SYNC_CTRL, 8'h00);
        reg_wr(13'h0100, 8'hFF);
        reg_chk("unmapped", 13'h0100, 8'h00);
        // Every ratio from one to eight
        for (int r = 1; r <= 8; r++) begin
            reg_wr(scdsy_pkg::ADDR_RATIO, 8'(r - 1));
            reg_chk("ratio_reg", scdsy_pkg::ADDR_RATIO, 8'(r - 1));
            wait_valid(t0);
            tick(1);
            wait_valid(t1);
            check("valid_period", 16'(r), 16'(t1 - t0));
            // High cycles of the conversion clock over one period
            hi = 0;
            for (int k = 0; k < r; k++) begin
                hi += conv_clk_o;
                tick(1);
            end
            check("conv_clk_high", 16'((r + 1) / 2), 16'(hi));
        end
        // Corrected words, including a saturating one
        reg_wr(scdsy_pkg::ADDR_RATIO, 8'h00);
        for (int i = 0; i < 3; i++) begin
            codes_i[0] = tbl[i];
            codes_i[1] = tbl[2 - i];
            tick(8);
            ew = ref_word(tbl[i]);
            check("data_o0", {1'b0, ew}, {1'b0, data_o[0]});
            ew = ref_word(tbl[2 - i]);
            check("data_o1", {1'b0, ew}, {1'b0, data_o[1]});
        end
        // Power-down by pin and by register
        pdwn_i = 1'b1;
        tick(8);
        check("data_oe_pin", 16'h0000, {15'h0000, data_oe_o});
        pdwn_i = 1'b0;
        tick(8);
        check("data_oe_run", 16'h0001, {15'h0000, data_oe_o});
        reg_wr(scdsy_pkg::ADDR_POWER, 8'h01);
        check("data_oe_reg", 16'h0000, {15'h0000, data_oe_o});
        reg_wr(scdsy_pkg::ADDR_POWER, 8'h00);
        check("data_oe_run", 16'h0001, {15'h0000, data_oe_o});
        // Realign on every pulse at divide by eight
        reg_wr(scdsy_pkg::ADDR_RATIO, 8'h07);
        reg_wr(scdsy_pkg::ADDR_SYNC_CTRL, 8'h02);
        pulse_at(0);
        wait_valid(t0);
        ph_a = t0 % 8;
        pulse_at(3);
        wait_valid(t0);
        check("every_pulse", 16'((ph_a + 3) % 8), 16'(t0 % 8));
        // First pulse only: write arms, pulse disarms, later pulse ignored
        reg_wr(scdsy_pkg::ADDR_SYNC_CTRL, 8'h06);
        reg_chk("armed", scdsy_pkg::ADDR_SYNC_CTRL, 8'h0E);
        pulse_at(5);
        wait_valid(t0);
        check("first_pulse", 16'((ph_a + 5) % 8), 16'(t0 % 8));
        reg_chk("disarmed", scdsy_pkg::ADDR_SYNC_CTRL, 8'h06);
        pulse_at(1);
        wait_valid(t1);
        check("later_pulse", 16'(t0 % 8), 16'(t1 % 8));
        // Alignment switched off
        reg_wr(scdsy_pkg::ADDR_SYNC_CTRL, 8'h00);
        pulse_at(2);
        wait_valid(t0);
        check("sync_off", 16'(t1 % 8), 16'(t0 % 8));
        // Corrector off, then a second reset restores it
        reg_wr(scdsy_pkg::ADDR_DCC, 8'h00);
        check("dcc_off", 16'h0000, {15'h0000, dcc_enable_o});
        reset_n_i = 1'b0;
        tick(3);
        reset_n_i = 1'b1;
        tick(6);
        check("dcc_again", 16'h0001, {15'h0000, dcc_enable_o});
        reg_chk("ratio_again", scdsy_pkg::ADDR_RATIO, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
